// file: verilog/wdtdt_pkg.sv
// Purpose: constants and types of the watchdog and discharge timer block
// Assumes: 40 MHz core clock, byte-wide register port
// Notes: timeout codes count in half-minute units

package wdtdt_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_HZ = 40_000_000;
   localparam int WD_TIME_MS = 2000;
   localparam int WD_CYCLES_DEF = WD_TIME_MS * (CLK_HZ / 1000);
   localparam int HALF_MIN_S = 30;
   localparam int HALF_MIN_CYCLES_DEF = HALF_MIN_S * CLK_HZ;

   // ****************************************
   // register map and fields
   // ****************************************
   localparam int CFG_A_BYTES = 6;
   localparam int CFG_B_BYTES = 2;
   localparam int SW_BYTES = 9;
   localparam logic [7:0] ADDR_CFG_A = 8'h00;
   localparam logic [7:0] ADDR_CFG_B = 8'h06;
   localparam logic [7:0] ADDR_STAT_B = 8'h08;
   localparam logic [7:0] ADDR_TMR_STAT = 8'h09;
   localparam logic [7:0] ADDR_SW = 8'h10;
   localparam int CODE_BYTE = 5;
   localparam int CODE_LSB = 4;
   localparam int MUTE_BIT = 7;
   localparam int MON_EN_BIT = 3;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] CODE_OFF = 4'h0;
   localparam int DIS_BITS = 18;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      WDTDT_NOP, WDTDT_WR_CFG_A, WDTDT_RD_CFG_A, WDTDT_RD_CFG_B, WDTDT_RD_STAT_B,
      WDTDT_CLR_STAT, WDTDT_AUX_CONV, WDTDT_AUX_OW
   } wdtdt_cmd_t;

   typedef enum logic [1:0] {WDTDT_ACTIVE, WDTDT_EXT_BAL, WDTDT_SLEEP} wdtdt_mode_t;

   typedef struct packed {
      logic done;          // command finished on the link
      logic pec_ok;        // command error check matched
      wdtdt_cmd_t code;    // decoded command
      logic pull_up;       // pull_up_select of an open-wire command
   } wdtdt_cmd_bus_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wdtdt_reg_req_t;

endpackage : wdtdt_pkg

// file: verilog/wdtdt_core.sv
// Purpose: command watchdog, cell discharge timer, thermal trip and aux open-wire control
// Assumes: command decoder and register port on core_clk; pins are asynchronous
// Notes: all state lives in one struct, one comb fill, one register

`timescale 1ns/1ps

module wdtdt_core
   import wdtdt_pkg::*;
#(
   parameter int WD_CYCLES = WD_CYCLES_DEF,
   parameter int HALF_MIN_CYCLES = HALF_MIN_CYCLES_DEF,
   parameter logic [3:0] REV_CODE = 4'h0 // arbitrary value
) (
   input wire logic core_clk, // 40 MHz core clock
   input wire logic arst_n, // async reset, active low
   input wire wdtdt_cmd_bus_t cmd, // decoded command, done is a pulse
   input wire wdtdt_reg_req_t req, // register port request
   output logic [7:0] rdata, // read data, cycle after rd
   input wire logic timer_enable_pin, // discharge timer enable pin
   input wire logic thermal_trip_pin, // die over-temperature detector
   output logic watchdog_out_pin_o, // pin drive value, always low
   output logic watchdog_out_pin_oe, // high while pin pulled low
   output logic [DIS_BITS-1:0] discharge_out, // cell discharge switches
   output wdtdt_mode_t mode, // active, extended balancing or sleep
   output logic aux_conv_start, // one-cycle aux conversion start
   output logic aux_cur_src_en, // pin current sources on
   output logic aux_cur_pull_up // source when high, sink when low
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [CFG_A_BYTES-1:0][7:0] cfg_a;
      logic [CFG_A_BYTES-1:0][7:0] cfg_a_sh;
      logic [CFG_B_BYTES-1:0][7:0] cfg_b;
      logic [SW_BYTES-1:0][7:0] sw;
      logic [31:0] wd_cnt;
      logic wd_exp;
      logic [31:0] pre;
      logic [7:0] rem;
      wdtdt_mode_t mode;
      logic therm_flag;
      logic therm_s1;
      logic therm_s2;
      logic therm_prev;
      logic en_s1;
      logic en_s2;
      logic [7:0] rdata;
      logic [DIS_BITS-1:0] dis;
      logic conv;
      logic cur_en;
      logic pull_up_select;
      logic wdt_oe;
   } wdtdt_state_t;

   wdtdt_state_t st_r;
   wdtdt_state_t st_nxt;

   // ****************************************
   // timeout code helpers and register read mux
   // ****************************************
   function automatic logic [7:0] code_halves(input logic [3:0] c);
      logic [7:0] h;
      h = 8'h00;
      unique case (c)
         4'h0: h = 8'h00;
         4'h1: h = 8'h01;
         4'h2: h = 8'h02;
         4'h3: h = 8'h04;
         4'h4: h = 8'h06;
         4'h5: h = 8'h08;
         4'h6: h = 8'h0A;
         4'h7: h = 8'h14;
         4'h8: h = 8'h1E;
         4'h9: h = 8'h28;
         4'hA: h = 8'h3C;
         4'hB: h = 8'h50;
         4'hC: h = 8'h78;
         4'hD: h = 8'h96;
         4'hE: h = 8'hB4;
         4'hF: h = 8'hF0;
      endcase
      return h;
   endfunction : code_halves

   // remaining halves r means time left in (r-1, r] half minutes
   function automatic logic [3:0] bucket(input logic [7:0] r);
      logic [3:0] b;
      b = 4'h0;
      for (int i = 15; i >= 1; i--) begin
         if (r != 8'h00 && r <= code_halves(4'(i))) begin
            b = 4'(i);
         end
      end
      return b;
   endfunction : bucket

   function automatic logic [7:0] read_mux(input wdtdt_state_t s, input logic [7:0] a);
      logic [7:0] d;
      d = 8'h00;
      if (a < ADDR_CFG_A + 8'(CFG_A_BYTES)) begin
         d = s.cfg_a[3'(a - ADDR_CFG_A)];
         if (a == ADDR_CFG_A + 8'(CODE_BYTE)) begin
            d[CODE_LSB +: 4] = bucket(s.rem);
         end
      end else if (a >= ADDR_CFG_B && a < ADDR_CFG_B + 8'(CFG_B_BYTES)) begin
         d = s.cfg_b[1'(a - ADDR_CFG_B)];
      end else if (a == ADDR_STAT_B) begin
         d = {REV_CODE, 3'h0, s.therm_flag};
      end else if (a == ADDR_TMR_STAT) begin
         d = {4'h0, s.en_s2, s.rem != 8'h00, s.wd_exp, s.mode == WDTDT_SLEEP};
      end else if (a >= ADDR_SW && a < ADDR_SW + 8'(SW_BYTES)) begin
         d = s.sw[4'(a - ADDR_SW)];
      end
      return d;
   endfunction : read_mux

   // ****************************************
   // next state
   // ****************************************
   logic cmd_ok;
   logic wd_fire;
   logic dt_fire;
   logic dt_run;
   logic therm_fire;
   logic [3:0] new_code;

   always_comb begin
      st_nxt = st_r;
      cmd_ok = cmd.done && cmd.pec_ok;
      dt_run = st_r.en_s2 && st_r.rem != 8'h00;
      wd_fire = 1'b0;
      dt_fire = 1'b0;
      new_code = st_r.cfg_a_sh[CODE_BYTE][CODE_LSB +: 4];

      // pins pass two flops before any use
      st_nxt.therm_s1 = thermal_trip_pin;
      st_nxt.therm_s2 = st_r.therm_s1;
      st_nxt.therm_prev = st_r.therm_s2;
      st_nxt.en_s1 = timer_enable_pin;
      st_nxt.en_s2 = st_r.en_s1;
      therm_fire = st_r.therm_s2 && !st_r.therm_prev;

      // watchdog count, sticky once expired
      if (cmd_ok) begin
         st_nxt.wd_cnt = 32'h0;
         st_nxt.wd_exp = 1'b0;
         st_nxt.mode = WDTDT_ACTIVE;
      end else if (!st_r.wd_exp) begin
         if (st_r.wd_cnt == 32'(WD_CYCLES)) begin
            st_nxt.wd_exp = 1'b1;
            wd_fire = 1'b1;
         end else begin
            st_nxt.wd_cnt = st_r.wd_cnt + 32'h1;
         end
      end

      // discharge timer, only a group A write reloads it
      if (!st_r.en_s2) begin
         st_nxt.rem = 8'h00;
         st_nxt.pre = 32'h0;
      end else if (dt_run) begin
         if (st_r.pre == 32'(HALF_MIN_CYCLES - 1)) begin
            st_nxt.pre = 32'h0;
            st_nxt.rem = st_r.rem - 8'h01;
            dt_fire = st_r.rem == 8'h01;
         end else begin
            st_nxt.pre = st_r.pre + 32'h1;
         end
      end

      // watchdog and timer expiry resets
      if (wd_fire && dt_run && !dt_fire) begin
         st_nxt.cfg_a[0] = RST_BYTE;
         if (!st_r.cfg_b[1][MON_EN_BIT]) begin
            st_nxt.cfg_a[3:1] = '0;
         end
         st_nxt.cfg_b[0][3:0] = 4'h0;
         st_nxt.mode = WDTDT_EXT_BAL;
      end else if (wd_fire || (dt_fire && st_r.wd_exp)) begin
         st_nxt.cfg_a = '0;
         st_nxt.cfg_b = '0;
         st_nxt.sw = '0;
         st_nxt.rem = 8'h00;
         st_nxt.mode = WDTDT_SLEEP;
      end else if (dt_fire) begin
         // live registers change mid-read, a read may see mixed bytes
         st_nxt.cfg_a[5:4] = '0;
         if (st_r.cfg_b[1][MON_EN_BIT]) begin
            st_nxt.cfg_a[3:1] = '0;
         end
         st_nxt.sw = '0;
         st_nxt.cfg_b[0][7:4] = 4'h0;
         st_nxt.cfg_b[1] = st_r.cfg_b[1] & (8'h01 << MUTE_BIT);
      end

      // thermal trip clears config except the mute bit, discharge follows config to zero
      if (therm_fire) begin
         st_nxt.cfg_a = '0;
         st_nxt.cfg_b = '0;
         st_nxt.cfg_b[1][MUTE_BIT] = st_r.cfg_b[1][MUTE_BIT];
         st_nxt.rem = 8'h00;
      end

      // thermal flag: setting beats the status read clear
      if (cmd_ok && cmd.code == WDTDT_RD_STAT_B) begin
         st_nxt.therm_flag = 1'b0;
      end
      if (therm_fire || (cmd_ok && cmd.code == WDTDT_CLR_STAT)) begin
         st_nxt.therm_flag = 1'b1;
      end

      // commands; group A commit comes after any expiry resets
      st_nxt.conv = 1'b0;
      if (cmd_ok && cmd.code == WDTDT_WR_CFG_A) begin
         st_nxt.cfg_a = st_r.cfg_a_sh;
         st_nxt.pre = 32'h0;
         if (st_r.en_s2 && new_code != CODE_OFF) begin
            st_nxt.rem = code_halves(new_code);
         end else begin
            st_nxt.rem = 8'h00;
         end
      end
      if (cmd_ok && (cmd.code == WDTDT_AUX_CONV || cmd.code == WDTDT_AUX_OW)) begin
         st_nxt.conv = 1'b1;
         st_nxt.cur_en = cmd.code == WDTDT_AUX_OW;
         st_nxt.pull_up_select = cmd.pull_up;
      end

      // register port: group A goes to the shadow until the write command
      if (req.wr) begin
         if (req.addr < ADDR_CFG_A + 8'(CFG_A_BYTES)) begin
            st_nxt.cfg_a_sh[3'(req.addr - ADDR_CFG_A)] = req.wdata;
         end else if (req.addr >= ADDR_CFG_B && req.addr < ADDR_CFG_B + 8'(CFG_B_BYTES)) begin
            st_nxt.cfg_b[1'(req.addr - ADDR_CFG_B)] = req.wdata;
         end else if (req.addr >= ADDR_SW && req.addr < ADDR_SW + 8'(SW_BYTES)) begin
            st_nxt.sw[4'(req.addr - ADDR_SW)] = req.wdata;
         end
      end
      st_nxt.rdata = req.rd ? read_mux(st_r, req.addr) : 8'h00;

      // outputs; switches follow the stored enables, kept through a watchdog expiry only while the timer runs
      st_nxt.dis = {st_nxt.cfg_b[1][1:0], st_nxt.cfg_b[0][7:4],
                    st_nxt.cfg_a[5][3:0], st_nxt.cfg_a[4]};
      st_nxt.wdt_oe = !st_nxt.wd_exp;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
         st_r.wdt_oe <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata = st_r.rdata;
   assign watchdog_out_pin_o = 1'b0;
   assign watchdog_out_pin_oe = st_r.wdt_oe;
   assign discharge_out = st_r.dis;
   assign mode = st_r.mode;
   assign aux_conv_start = st_r.conv;
   assign aux_cur_src_en = st_r.cur_en;
   assign aux_cur_pull_up = st_r.pull_up_select;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   property p_wd_expire;
      !st_r.wd_exp && st_r.wd_cnt == 32'(WD_CYCLES) && !cmd_ok |=> st_r.wd_exp;
   endproperty
   a_wd_expire: assert property (p_wd_expire) else $error("watchdog missed expiry");

   property p_wd_restart;
      cmd_ok |=> st_r.wd_cnt == 32'h0 && !st_r.wd_exp;
   endproperty
   a_wd_restart: assert property (p_wd_restart) else $error("valid command no restart");

   property p_wd_sticky;
      st_r.wd_exp && !cmd_ok |=> st_r.wd_exp;
   endproperty
   a_wd_sticky: assert property (p_wd_sticky) else $error("expired state dropped");

   property p_pin;
      st_r.wd_exp |=> !watchdog_out_pin_oe || $past(cmd_ok);
   endproperty
   a_pin: assert property (p_pin) else $error("watchdog pin still driven");

   property p_ext_bal;
      wd_fire && dt_run && !dt_fire && !therm_fire |=> mode == WDTDT_EXT_BAL
         && discharge_out == $past(discharge_out);
   endproperty
   a_ext_bal: assert property (p_ext_bal) else $error("timer run expiry wrong");

   property p_full_reset;
      wd_fire && !dt_run && !cmd_ok && !req.wr |=> mode == WDTDT_SLEEP && st_r.sw == '0
         && st_r.cfg_a == '0;
   endproperty
   a_full_reset: assert property (p_full_reset) else $error("watchdog reset missed");

   property p_dt_reset;
      dt_fire && !st_r.wd_exp && !req.wr && !cmd_ok |=> st_r.cfg_a[5:4] == '0
         && st_r.sw == '0;
   endproperty
   a_dt_reset: assert property (p_dt_reset) else $error("timer expiry reset missed");

   property p_load;
      cmd_ok && cmd.code == WDTDT_WR_CFG_A && st_r.en_s2 && new_code != CODE_OFF
         |=> st_r.rem == code_halves(new_code) && st_r.cfg_a == $past(st_r.cfg_a_sh);
   endproperty
   a_load: assert property (p_load) else $error("timer load wrong");

   property p_no_reload;
      !(cmd_ok && cmd.code == WDTDT_WR_CFG_A) && st_r.en_s2 |=> st_r.rem <= $past(st_r.rem);
   endproperty
   a_no_reload: assert property (p_no_reload) else $error("timer restarted");

   property p_therm;
      therm_fire |=> st_r.therm_flag && discharge_out == '0 ##1 st_r.therm_flag;
   endproperty
   a_therm: assert property (p_therm) else $error("thermal trip not handled");

   property p_clr_stat;
      cmd_ok && cmd.code == WDTDT_CLR_STAT |=> st_r.therm_flag;
   endproperty
   a_clr_stat: assert property (p_clr_stat) else $error("clear status flag");

   property p_aux;
      cmd_ok && cmd.code == WDTDT_AUX_OW |=> aux_conv_start && aux_cur_src_en
         ##1 !aux_conv_start;
   endproperty
   a_aux: assert property (p_aux) else $error("open-wire start wrong");

   c_ext_bal: cover property (wd_fire && dt_run);
   c_dt_fire: cover property (dt_fire && !st_r.wd_exp);
   c_therm: cover property (therm_fire);
   c_wr_during: cover property (dt_fire ##[1:20] cmd_ok && cmd.code == WDTDT_WR_CFG_A);

endmodule : wdtdt_core

// file: sim/wdtdt_host.sv
// Purpose: host controller model driving commands and register accesses
// Assumes: every request starts right after a rising edge and is held one cycle
// Notes: released address and data lines show the inverse of their last value

`timescale 1ns/1ps

module wdtdt_host
   import wdtdt_pkg::*;
(
   input wire logic core_clk, // core clock
   output wdtdt_cmd_bus_t cmd, // command to the block
   output wdtdt_reg_req_t req, // register port request
   input wire logic [7:0] rdata // read data, cycle after rd
);
   initial begin
      cmd = '0;
      req = '0;
   end

   // ****************************************
   // register port
   // ****************************************
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask : reg_wr

   // whole byte taken, never trusted across a timer expiry
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
      @(negedge core_clk);
      d = rdata;
   endtask : reg_rd

   // ****************************************
   // command link
   // ****************************************
   task automatic send(input wdtdt_cmd_t c, input logic ok, input logic pu);
      @(posedge core_clk);
      cmd <= '{done: 1'b1, pec_ok: ok, code: c, pull_up: pu};
      @(posedge core_clk);
      cmd <= '{done: 1'b0, pec_ok: ~ok, code: c, pull_up: ~pu};
   endtask : send
endmodule : wdtdt_host

// file: sim/tb_top.sv
// Purpose: self-checking bench for the watchdog and discharge timer
// Assumes: shortened counts, 50 cycle watchdog and 20 cycle half minute
// Notes: host model issues every access; pins are driven by the bench

`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end

module tb_top
   import wdtdt_pkg::*;
;
   localparam int WD = 50;
   localparam int HM = 20;
   logic core_clk;
   logic arst_n;
   logic ten;
   logic ttrip;
   wdtdt_cmd_bus_t cmd;
   wdtdt_reg_req_t req;
   logic [7:0] rdata;
   logic pin_o;
   logic oe;
   logic [DIS_BITS-1:0] dis;
   wdtdt_mode_t mode;
   logic conv;
   logic src_en;
   logic pull_up;
   logic [7:0] v;
   int bad_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int t0;
   int n;
   int halves [16] = '{0, 1, 2, 4, 6, 8, 10, 20, 30, 40, 60, 80, 120, 150, 180, 240};

   wdtdt_core #(.WD_CYCLES(WD), .HALF_MIN_CYCLES(HM), .REV_CODE(4'hA)) dut ( // rev arbitrary
      .core_clk(core_clk), .arst_n(arst_n), .cmd(cmd), .req(req), .rdata(rdata),
      .timer_enable_pin(ten), .thermal_trip_pin(ttrip), .watchdog_out_pin_o(pin_o),
      .watchdog_out_pin_oe(oe), .discharge_out(dis), .mode(mode),
      .aux_conv_start(conv), .aux_cur_src_en(src_en), .aux_cur_pull_up(pull_up));

   wdtdt_host host (.core_clk(core_clk), .cmd(cmd), .req(req), .rdata(rdata));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // ****************************************
   // helpers
   // ****************************************
   task automatic tally_and_finish;
      if (bad_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   // generous ceiling: the code sweep alone needs about 19000 cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   task automatic expect_rd(input logic [7:0] a, input logic [7:0] e);
      host.reg_rd(a, v);
      `CHK(v, e)
   endtask : expect_rd

   task automatic wait_until_low(input bit sw);
      n = 0;
      while (((sw ? (dis !== '0) : (oe !== 1'b0))) && n < 6000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
   endtask : wait_until_low

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      arst_n = 1'b0;
      ten = 1'b0;
      ttrip = 1'b0;
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      #1;
      `CHK(oe, 1'b1)
      `CHK(mode, WDTDT_ACTIVE)
      `CHK(pin_o, 1'b0)
      // timer off: full reset on expiry
      for (int i = 0; i < 6; i++) host.reg_wr(ADDR_CFG_A + 8'(i), 8'h11 * 8'(i + 1));
      host.reg_wr(8'h06, 8'hFF);
      host.reg_wr(8'h07, 8'h88);
      host.reg_wr(ADDR_SW, 8'hA5);
      host.send(WDTDT_WR_CFG_A, 1'b1, 1'b0);
      t0 = cyc;
      expect_rd(8'h04, 8'h55);
      expect_rd(8'h05, 8'h06);
      `CHK(dis, {2'b00, 4'hF, 4'h6, 8'h55})
      wait_until_low(1'b0);
      `CHK(1'((cyc - t0) >= WD + 1 && (cyc - t0) <= WD + 3), 1'b1)
      expect_rd(8'h00, 8'h00);
      expect_rd(8'h05, 8'h00);
      expect_rd(8'h06, 8'h00);
      expect_rd(8'h07, 8'h00);
      expect_rd(ADDR_SW, 8'h00);
      `CHK(dis, '0)
      `CHK(mode, WDTDT_SLEEP)
      host.send(WDTDT_NOP, 1'b0, 1'b0);
      #1;
      `CHK(oe, 1'b0)
      host.send(WDTDT_NOP, 1'b1, 1'b0);
      #1;
      `CHK(oe, 1'b1)
      // timer running through a watchdog expiry
      ten <= 1'b1;
      for (int i = 0; i < 4; i++) host.reg_wr(ADDR_CFG_A + 8'(i), 8'h11);
      host.reg_wr(8'h04, 8'hF0);
      host.reg_wr(8'h05, 8'h3C);
      host.reg_wr(8'h06, 8'h5F);
      host.reg_wr(8'h07, 8'h83);
      host.send(WDTDT_WR_CFG_A, 1'b1, 1'b0);
      expect_rd(8'h05, 8'h3C);
      wait_until_low(1'b0);
      #1;
      `CHK(mode, WDTDT_EXT_BAL)
      `CHK(dis, {2'b11, 4'h5, 4'hC, 8'hF0})
      expect_rd(8'h00, 8'h00);
      expect_rd(8'h01, 8'h00);
      expect_rd(8'h06, 8'h50);
      wait_until_low(1'b1);
      expect_rd(8'h04, 8'h00);
      expect_rd(8'h06, 8'h00);
      expect_rd(8'h07, 8'h00);
      `CHK(mode, WDTDT_SLEEP)
      // every nonzero timeout code, timed from the group A write
      host.reg_wr(8'h04, 8'h00);
      for (int c = 1; c < 16; c++) begin
         host.reg_wr(8'h05, {4'(c), 4'hF});
         host.send(WDTDT_WR_CFG_A, 1'b1, 1'b0);
         t0 = cyc;
         expect_rd(8'h05, {4'(c), 4'hF});
         host.send(WDTDT_CLR_STAT, 1'b1, 1'b0);
         wait_until_low(1'b1);
         n = cyc - t0 - halves[c] * HM;
         `CHK(1'(n >= 0 && n <= 3), 1'b1)
         expect_rd(8'h05, 8'h00);
      end
      // thermal flag and trip
      ten <= 1'b0;
      host.reg_wr(8'h00, 8'h77);
      host.send(WDTDT_WR_CFG_A, 1'b1, 1'b0);
      host.reg_wr(8'h07, 8'h88);
      host.send(WDTDT_CLR_STAT, 1'b1, 1'b0);
      expect_rd(ADDR_STAT_B, 8'hA1);
      expect_rd(8'h00, 8'h77);
      host.send(WDTDT_RD_STAT_B, 1'b1, 1'b0);
      expect_rd(ADDR_STAT_B, 8'hA0);
      ttrip <= 1'b1;
      repeat (5) @(posedge core_clk);
      expect_rd(ADDR_STAT_B, 8'hA1);
      expect_rd(8'h00, 8'h00);
      expect_rd(8'h07, 8'h80);
      `CHK(dis, '0)
      ttrip <= 1'b0;
      // auxiliary conversions
      host.send(WDTDT_AUX_OW, 1'b1, 1'b1);
      #1;
      `CHK({conv, src_en, pull_up}, 3'b111)
      @(posedge core_clk);
      #1;
      `CHK(conv, 1'b0)
      host.send(WDTDT_AUX_CONV, 1'b1, 1'b0);
      #1;
      `CHK({conv, src_en, pull_up}, 3'b100)
      tally_and_finish();
   end
endmodule : tb_top
